// *** inc/ccsu_defines.svh ***
/*
 * Register offsets, reset values and fixed values of the common command
 * and status unit. Assumes a 12-bit APB byte address.
 */
`ifndef CCSU_DEFINES_SVH
`define CCSU_DEFINES_SVH

`define CCSU_OFF_CMD      12'h000
`define CCSU_OFF_RESP     12'h004
`define CCSU_OFF_STATUS   12'h008
`define CCSU_OFF_SRE      12'h00C
`define CCSU_OFF_PCB      12'h010
`define CCSU_OFF_ID_CO    12'h014
`define CCSU_OFF_ID_MOD   12'h018
`define CCSU_OFF_SER0     12'h01C
`define CCSU_OFF_SER1     12'h020
`define CCSU_OFF_SER2     12'h024

`define CCSU_EN_RST       8'h00
`define CCSU_PCB_RST      5'h00
`define CCSU_ESE_MAX      16'sh00FF
`define CCSU_PCB_MAX      16'sh001E
`define CCSU_PSC_LOW      16'sh8000
`define CCSU_SRE_MASK     8'hBF
`define CCSU_PON_BIT      7

// Identity words: values are arbitrary
`define CCSU_ID_COMPANY   32'h4143_4D45
`define CCSU_ID_MODEL     32'h0000_0001
`define CCSU_SERIAL0      32'h3030_3030
`define CCSU_SERIAL1      32'h3030_3030
`define CCSU_SERIAL2      32'h0000_3030

`endif

// *** inc/ccsu_pkg.sv ***
/*
 * Types of the common command and status unit.
 * Assumes the command word layout is shared by software and logic.
 */
package ccsu_pkg;
    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_CAL_Q = 4'h1,
        CMD_CLS   = 4'h2,
        CMD_ESE   = 4'h3,
        CMD_ESE_Q = 4'h4,
        CMD_ESR_Q = 4'h5,
        CMD_IDN_Q = 4'h6,
        CMD_OPC   = 4'h7,
        CMD_OPC_Q = 4'h8,
        CMD_PCB   = 4'h9,
        CMD_PSC   = 4'hA,
        CMD_PSC_Q = 4'hB,
        CMD_RST   = 4'hC
    } ccsu_cmd_t;

    typedef enum logic [1:0] {
        BND_NUM = 2'h0,
        BND_MIN = 2'h1,
        BND_MAX = 2'h2
    } ccsu_bound_t;

    typedef struct packed {
        logic [15:0] arg;
        logic [4:0]  sec;
        logic        sec_en;
        ccsu_bound_t bound;
        logic [3:0]  pad;
        ccsu_cmd_t   op;
    } ccsu_cmd_word_t;

    typedef struct packed {
        logic        valid;
        logic [10:0] pad;
        ccsu_cmd_t   kind;
        logic [15:0] value;
    } ccsu_resp_t;

    typedef enum logic {
        CAL_IDLE = 1'b0,
        CAL_RUN  = 1'b1
    } ccsu_cal_state_t;
endpackage : ccsu_pkg

// *** rtl/ccsu_core.sv ***
/*
 * Common command and status unit: APB slave, command decode, standard
 * event and enable registers, status byte, service request and
 * nonvolatile settings. Assumes the nonvolatile store, the calibration
 * engine and the other status register sets run on clk_sys_i.
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

`include "ccsu_defines.svh"

module ccsu_core (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [6:1]  ev_cond_i,
    input  wire logic [3:0]  sum_i,
    input  wire logic        op_start_i,
    input  wire logic        op_done_i,
    input  wire logic        preset_done_i,
    input  wire logic        dev_clear_i,
    input  wire logic        cal_done_i,
    input  wire logic        cal_fail_i,
    input  wire logic        ctrl_release_i,
    input  wire logic [7:0]  nv_ese_i,
    input  wire logic [7:0]  nv_sre_i,
    input  wire logic        nv_psc_i,
    input  wire logic [10:0] nv_pcb_i,
    output logic      [7:0]  stb_o,
    output logic             srq_o,
    output logic             clear_events_o,
    output logic             preset_o,
    output logic             cal_start_o,
    output logic             pass_back_o,
    output logic      [7:0]  ese_o,
    output logic      [7:0]  sre_o,
    output logic             psc_o,
    output logic      [4:0]  pcb_primary_o,
    output logic      [4:0]  pcb_secondary_o,
    output logic             pcb_sec_valid_o
);
    function automatic logic in_range(input logic signed [15:0] v,
                                      input logic signed [15:0] lo,
                                      input logic signed [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    ccsu_pkg::ccsu_resp_t      resp;
    ccsu_pkg::ccsu_resp_t      next_resp;
    ccsu_pkg::ccsu_cal_state_t cal_state;
    logic [7:0]                esr;
    logic [7:0]                svc_prev;
    logic [6:1]                ev_prev;
    logic [3:0]                err_cnt;
    logic                      pwr_load;
    logic                      opc_event;
    logic                      opc_resp;

    // Bus decode
    wire acc      = psel_i & penable_i & ~pready_o;
    wire wr       = acc & pwrite_i;
    wire rd       = acc & ~pwrite_i;
    wire hit_cmd  = (paddr_i == `CCSU_OFF_CMD);
    wire hit_resp = (paddr_i == `CCSU_OFF_RESP);
    wire hit_stat = (paddr_i == `CCSU_OFF_STATUS);
    wire hit_sre  = (paddr_i == `CCSU_OFF_SRE);
    wire hit_pcb  = (paddr_i == `CCSU_OFF_PCB);
    wire hit_co   = (paddr_i == `CCSU_OFF_ID_CO);
    wire hit_mod  = (paddr_i == `CCSU_OFF_ID_MOD);
    wire hit_s0   = (paddr_i == `CCSU_OFF_SER0);
    wire hit_s1   = (paddr_i == `CCSU_OFF_SER1);
    wire hit_s2   = (paddr_i == `CCSU_OFF_SER2);
    wire mapped   = hit_cmd | hit_resp | hit_stat | hit_sre | hit_pcb
                  | hit_co | hit_mod | hit_s0 | hit_s1 | hit_s2;

    // Command word fields
    ccsu_pkg::ccsu_cmd_word_t cw;
    assign cw = pwdata_i;
    wire                     cmd_go = wr & hit_cmd;
    wire signed [15:0]       arg    = cw.arg;
    wire                     b_num  = (cw.bound == ccsu_pkg::BND_NUM);
    wire                     b_min  = (cw.bound == ccsu_pkg::BND_MIN);
    wire                     b_max  = (cw.bound == ccsu_pkg::BND_MAX);

    wire is_cal   = cmd_go & (cw.op == ccsu_pkg::CMD_CAL_Q);
    wire is_cls   = cmd_go & (cw.op == ccsu_pkg::CMD_CLS);
    wire is_ese   = cmd_go & (cw.op == ccsu_pkg::CMD_ESE);
    wire is_eseq  = cmd_go & (cw.op == ccsu_pkg::CMD_ESE_Q);
    wire is_esrq  = cmd_go & (cw.op == ccsu_pkg::CMD_ESR_Q);
    wire is_idn   = cmd_go & (cw.op == ccsu_pkg::CMD_IDN_Q);
    wire is_opc   = cmd_go & (cw.op == ccsu_pkg::CMD_OPC);
    wire is_opcq  = cmd_go & (cw.op == ccsu_pkg::CMD_OPC_Q);
    wire is_pcb   = cmd_go & (cw.op == ccsu_pkg::CMD_PCB);
    wire is_psc   = cmd_go & (cw.op == ccsu_pkg::CMD_PSC);
    wire is_pscq  = cmd_go & (cw.op == ccsu_pkg::CMD_PSC_Q);
    wire is_rst   = cmd_go & (cw.op == ccsu_pkg::CMD_RST);
    wire is_bad   = cmd_go & (cw.op > ccsu_pkg::CMD_RST || cw.op == ccsu_pkg::CMD_NONE);

    wire [7:0] ese_val = b_max ? 8'(`CCSU_ESE_MAX) : (b_min ? 8'h00 : arg[7:0]);
    wire ese_ok  = b_min | b_max | (b_num & in_range(arg, 16'sh0000, `CCSU_ESE_MAX));
    wire [4:0] pcb_val = b_max ? 5'(`CCSU_PCB_MAX) : (b_min ? 5'h00 : arg[4:0]);
    wire pcb_ok  = (b_min | b_max | (b_num & in_range(arg, 16'sh0000, `CCSU_PCB_MAX)))
                 & (~cw.sec_en | (cw.sec <= `CCSU_PCB_MAX));
    wire psc_ok  = ~b_num | (arg != `CCSU_PSC_LOW);
    wire psc_val = ~b_num | (arg != 16'sh0000);
    wire err_ev  = is_bad | (is_ese & ~ese_ok) | (is_pcb & ~pcb_ok)
                 | (is_psc & ~psc_ok) | (cmd_go & ~b_num & ~b_min & ~b_max);

    wire cancel  = is_cls | is_rst | dev_clear_i;
    wire cal_end = (cal_state == ccsu_pkg::CAL_RUN) & cal_done_i;

    wire [7:0] ev_set = {pwr_load, ev_cond_i & ~ev_prev, opc_event};
    wire       esr_clr = is_cls | is_esrq;
    wire [7:0] next_esr = (esr_clr ? 8'h00 : esr) | ev_set;

    wire       message_available_bit = resp.valid;
    wire       esb = |(esr & ese_o);
    wire [7:0] stb_raw = {sum_i[3], 1'b0, esb, message_available_bit, sum_i[2], sum_i[1], 1'b0, sum_i[0]};
    wire       master_summary_bit = |(stb_raw & sre_o & `CCSU_SRE_MASK);
    wire [7:0] next_stb = stb_raw | {1'b0, master_summary_bit, 6'h00};
    wire [7:0] svc = stb_o & sre_o & `CCSU_SRE_MASK;

    function automatic ccsu_pkg::ccsu_resp_t mk(input ccsu_pkg::ccsu_cmd_t k,
                                                input logic [15:0] v);
        mk = '{valid: 1'b1, pad: 11'h000, kind: k, value: v};
    endfunction : mk

    // Queue a response; calibration and completion win over a new query
    always_comb begin
        next_resp = resp;
        if (rd & hit_resp) begin
            next_resp.valid = 1'b0;
        end
        if (cal_end) begin
            next_resp = mk(ccsu_pkg::CMD_CAL_Q, {15'h0000, cal_fail_i});
        end else if (opc_resp) begin
            next_resp = mk(ccsu_pkg::CMD_OPC_Q, 16'h0001);
        end else if (is_eseq) begin
            next_resp = mk(ccsu_pkg::CMD_ESE_Q, {8'h00, ese_o});
        end else if (is_esrq) begin
            next_resp = mk(ccsu_pkg::CMD_ESR_Q, {8'h00, esr});
        end else if (is_idn) begin
            next_resp = mk(ccsu_pkg::CMD_IDN_Q, 16'h0000);
        end else if (is_pscq) begin
            next_resp = mk(ccsu_pkg::CMD_PSC_Q, {15'h0000, psc_o});
        end
    end

    logic [31:0] rdata;
    assign rdata = hit_resp ? resp
                 : hit_stat ? {4'h0, err_cnt, esr, ese_o, stb_o}
                 : hit_sre  ? {24'h00_0000, sre_o}
                 : hit_pcb  ? {20'h0_0000, pcb_sec_valid_o, pcb_secondary_o, 1'b0, pcb_primary_o}
                 : hit_co   ? `CCSU_ID_COMPANY
                 : hit_mod  ? `CCSU_ID_MODEL
                 : hit_s0   ? `CCSU_SERIAL0
                 : hit_s1   ? `CCSU_SERIAL1
                 : hit_s2   ? `CCSU_SERIAL2
                 : 32'h0000_0000;

    // APB: one wait state, answer registered
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= acc;
            pslverr_o <= acc & ~mapped;
            prdata_o  <= rd ? rdata : 32'h0000_0000;
        end
    end

    // Status and events
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            esr            <= 8'h00;
            ev_prev        <= 6'h00;
            err_cnt        <= 4'h0;
            resp           <= '0;
            stb_o          <= 8'h00;
            svc_prev       <= 8'h00;
            srq_o          <= 1'b0;
            clear_events_o <= 1'b0;
        end else begin
            esr            <= next_esr;
            ev_prev        <= ev_cond_i;
            resp           <= next_resp;
            stb_o          <= next_stb;
            svc_prev       <= svc;
            srq_o          <= |(svc & ~svc_prev);
            clear_events_o <= is_cls;
            if (is_cls) begin
                err_cnt <= 4'h0;
            end else if (err_ev && err_cnt != 4'hF) begin
                err_cnt <= err_cnt + 4'h1;
            end
        end
    end

    // Nonvolatile settings; power-up load one cycle after reset release
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pwr_load        <= 1'b1;
            ese_o           <= `CCSU_EN_RST;
            sre_o           <= `CCSU_EN_RST;
            psc_o           <= 1'b0;
            pcb_primary_o   <= `CCSU_PCB_RST;
            pcb_secondary_o <= `CCSU_PCB_RST;
            pcb_sec_valid_o <= 1'b0;
        end else begin
            pwr_load <= 1'b0;
            if (pwr_load) begin
                ese_o           <= nv_psc_i ? `CCSU_EN_RST : nv_ese_i;
                sre_o           <= nv_psc_i ? `CCSU_EN_RST : (nv_sre_i & `CCSU_SRE_MASK);
                psc_o           <= nv_psc_i;
                {pcb_sec_valid_o, pcb_secondary_o, pcb_primary_o} <= nv_pcb_i;
            end else begin
                if (is_ese && ese_ok) begin
                    ese_o <= ese_val;
                end
                if (wr && hit_sre) begin
                    sre_o <= pwdata_i[7:0] & `CCSU_SRE_MASK;
                end
                if (is_psc && psc_ok) begin
                    psc_o <= psc_val;
                end
                if (is_pcb && pcb_ok) begin
                    pcb_primary_o   <= pcb_val;
                    pcb_secondary_o <= cw.sec_en ? cw.sec : 5'h00;
                    pcb_sec_valid_o <= cw.sec_en;
                end
            end
        end
    end

    // Calibration, preset and pass-back strobes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cal_state   <= ccsu_pkg::CAL_IDLE;
            cal_start_o <= 1'b0;
            preset_o    <= 1'b0;
            pass_back_o <= 1'b0;
        end else begin
            cal_start_o <= is_cal & (cal_state == ccsu_pkg::CAL_IDLE);
            preset_o    <= is_rst;
            pass_back_o <= ctrl_release_i;
            unique case (cal_state)
                ccsu_pkg::CAL_IDLE: begin
                    if (is_cal) begin
                        cal_state <= ccsu_pkg::CAL_RUN;
                    end
                end
                ccsu_pkg::CAL_RUN: begin
                    if (cal_done_i) begin
                        cal_state <= ccsu_pkg::CAL_IDLE;
                    end
                end
            endcase
        end
    end

    ccsu_opc_tracker u_opc (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .start_i     ({is_rst, op_start_i}),
        .done_i      ({preset_done_i, op_done_i}),
        .arm_cmd_i   (is_opc),
        .arm_query_i (is_opcq),
        .cancel_i    (cancel),
        .opc_event_o (opc_event),
        .opc_resp_o  (opc_resp)
    );

    chk_esb_summary: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        stb_o[5] == |($past(esr) & $past(ese_o)))
        else $error("status bit 5 not the enabled event OR");
    chk_esr_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !esr_clr |=> (esr & $past(esr)) == $past(esr))
        else $error("latched event bit dropped");
    chk_esr_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        is_esrq |=> resp.valid && resp.value[7:0] == $past(esr) && esr == $past(ev_set))
        else $error("event query did not answer and clear");
    chk_cls_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        is_cls |=> clear_events_o && err_cnt == 4'h0 && esr == $past(ev_set))
        else $error("clear status incomplete");
    chk_cls_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        is_cls && !pwr_load |=> $stable(ese_o) && $stable(sre_o))
        else $error("clear status touched an enable");
    chk_ese_reject: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        is_ese && !ese_ok && err_cnt != 4'hF |=> $stable(ese_o) && err_cnt == $past(err_cnt) + 4'h1)
        else $error("bad enable value not refused");
    chk_mav_level: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        stb_o[4] == $past(resp.valid))
        else $error("message available bit wrong");
    chk_srq_edge: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        srq_o |-> $past(svc) != 8'h00 && ($past(svc) & ~$past(svc_prev)) != 8'h00)
        else $error("service request without rising cause");
    chk_rst_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        is_rst && !pwr_load |=> $stable(pcb_primary_o) && $stable(psc_o) ##1 preset_o == 1'b0)
        else $error("reset command touched nonvolatile settings");
    chk_cal_answer: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cal_end |=> resp.valid && resp.kind == ccsu_pkg::CMD_CAL_Q && resp.value[0] == $past(cal_fail_i))
        else $error("calibration answer wrong");

    cov_opc_query: cover property (@(posedge clk_sys_i) disable iff (reset_i) is_opcq ##[1:50] opc_resp);
    cov_srq: cover property (@(posedge clk_sys_i) disable iff (reset_i) is_opc ##[1:50] srq_o);
    cov_esr_read: cover property (@(posedge clk_sys_i) disable iff (reset_i) is_esrq && esr != 8'h00);
endmodule : ccsu_core

`default_nettype wire

// *** rtl/ccsu_opc_tracker.sv ***
/*
 * Pending overlapped operation counter and operation-complete arming.
 * Assumes start and done strobes come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccsu_opc_tracker (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic [1:0] start_i,
    input  wire logic [1:0] done_i,
    input  wire logic       arm_cmd_i,
    input  wire logic       arm_query_i,
    input  wire logic       cancel_i,
    output logic            opc_event_o,
    output logic            opc_resp_o
);
    logic [3:0] pending;
    logic       armed_cmd;
    logic       armed_qry;
    wire  [3:0] n_start = {3'h0, start_i[0]} + {3'h0, start_i[1]};
    wire  [3:0] n_done  = {3'h0, done_i[0]} + {3'h0, done_i[1]};
    wire  [3:0] up      = pending + n_start;
    wire  [3:0] next_pending = (up > n_done) ? up - n_done : 4'h0;
    wire        no_pending_operation_flag     = (pending == 4'h0);
    wire        fire_c  = armed_cmd & no_pending_operation_flag & ~cancel_i;
    wire        fire_q  = armed_qry & no_pending_operation_flag & ~cancel_i;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pending     <= 4'h0;
            armed_cmd   <= 1'b0;
            armed_qry   <= 1'b0;
            opc_event_o <= 1'b0;
            opc_resp_o  <= 1'b0;
        end else begin
            pending     <= next_pending;
            armed_cmd   <= ~cancel_i & ~fire_c & (armed_cmd | arm_cmd_i);
            armed_qry   <= ~cancel_i & ~fire_q & (armed_qry | arm_query_i);
            opc_event_o <= fire_c;
            opc_resp_o  <= fire_q;
        end
    end

    chk_opc_fire: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        armed_cmd && no_pending_operation_flag && !cancel_i |=> opc_event_o ##1 !opc_event_o)
        else $error("operation complete event missed");
    chk_opc_cancel: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cancel_i |=> !opc_event_o && !opc_resp_o)
        else $error("cancelled operation complete still fired");
    chk_npo_pend: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (start_i != 2'b00) && (done_i == 2'b00) && armed_qry |=> !opc_resp_o)
        else $error("response while operation pending");
endmodule : ccsu_opc_tracker

`default_nettype wire

// *** verification/ccsu_env_model.sv ***
/* Model of the calibration engine and preset logic around the core.
   Assumes one clock and one-cycle start pulses from the core. */
`timescale 1ns/1ps
`default_nettype none
module ccsu_env_model (
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    input  wire logic cal_start_i,
    input  wire logic preset_i,
    input  wire logic fail_i,
    output logic      cal_done_o,
    output logic      cal_fail_o,
    output logic      preset_done_o
);
    logic [3:0] cal_cnt;
    logic [3:0] pre_cnt;
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cal_cnt <= 4'h0;
            pre_cnt <= 4'h0;
        end else begin
            cal_cnt <= cal_start_i ? 4'h6 : cal_cnt - {3'h0, cal_cnt != 4'h0};
            pre_cnt <= preset_i ? 4'h3 : pre_cnt - {3'h0, pre_cnt != 4'h0};
        end
    end
    assign cal_done_o    = cal_cnt == 4'h1;
    // Fail level is only meaningful with the done pulse
    assign cal_fail_o    = cal_done_o ? fail_i : ~fail_i;
    assign preset_done_o = pre_cnt == 4'h1;
endmodule : ccsu_env_model
`default_nettype wire

// *** verification/testbench.sv ***
/* Self-checking bench of the common command and status unit.
   Assumes the APB timing and register map of the core. */
`timescale 1ns/1ps
`default_nettype none
`include "ccsu_defines.svh"
module testbench;
    logic        clk_sys_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        op_s = 1'b0, op_d = 1'b0, dclr = 1'b0, nv_psc = 1'b0, fail = 1'b0, slverr;
    logic        pready, pslverr, cal_start, preset, cal_done, cal_fail, pre_done;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [6:1]  ev = 6'h00;
    int          num_errors = 0, checks = 0;
    logic        rel = 1'b0, srq, pass_back, clr_ev;
    int          srq_n = 0, pb_n = 0, ce_n = 0;
    logic [15:0] ea [5] = '{16'h00FF, 16'h0000, 16'h0000, 16'h0100, 16'h0012};
    logic [7:0]  eb [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    logic [15:0] ee [5] = '{16'h00FF, 16'h0000, 16'h00FF, 16'h00FF, 16'h0012};
    always #25 clk_sys_i = ~clk_sys_i;
    ccsu_core dut_u (.clk_sys_i, .reset_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ev_cond_i(ev), .sum_i(4'h0), .op_start_i(op_s), .op_done_i(op_d), .preset_done_i(pre_done),
        .dev_clear_i(dclr), .cal_done_i(cal_done), .cal_fail_i(cal_fail), .ctrl_release_i(rel),
        .nv_ese_i(8'h5A), .nv_sre_i(8'h00), .nv_psc_i(nv_psc), .nv_pcb_i(11'h000), .stb_o(), .srq_o(srq),
        .clear_events_o(clr_ev), .preset_o(preset), .cal_start_o(cal_start), .pass_back_o(pass_back), .ese_o(),
        .sre_o(), .psc_o(), .pcb_primary_o(), .pcb_secondary_o(), .pcb_sec_valid_o());
    ccsu_env_model env_u (.clk_sys_i, .reset_i, .cal_start_i(cal_start), .preset_i(preset),
        .fail_i(fail), .cal_done_o(cal_done), .cal_fail_o(cal_fail), .preset_done_o(pre_done));
    // Count one-cycle output pulses
    always @(posedge clk_sys_i) begin
        if (!reset_i) begin
            srq_n <= srq_n + (srq ? 1 : 0);
            pb_n  <= pb_n + (pass_back ? 1 : 0);
            ce_n  <= ce_n + (clr_ev ? 1 : 0);
        end
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready !== 1'b1 && n < 9);
        q = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 9) begin
            num_errors++;
            $display("unexpected timeout on apb");
            print_verdict();
        end
    endtask : apb
    task automatic chk(input string s, input logic [31:0] e);
        checks++;
        if (q !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", s, e, q);
        end
    endtask : chk
    task automatic cmd(input ccsu_pkg::ccsu_cmd_t op, input logic [15:0] arg, input logic [7:0] b);
        apb(1'b1, `CCSU_OFF_CMD, {arg, b, 4'h0, op});
    endtask : cmd
    task automatic rd(input logic [11:0] a, input string s, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(s, e);
    endtask : rd
    task automatic st(input logic [31:0] e);
        rd(`CCSU_OFF_STATUS, "status", e);
    endtask : st
    task automatic rsp(input ccsu_pkg::ccsu_cmd_t k, input logic [15:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `CCSU_OFF_RESP, 32'h0000_0000);
            n++;
        end while (q[31] !== 1'b1 && n < 20);
        chk("resp", {1'b1, 11'h000, k, v});
    endtask : rsp
    task automatic no_rsp;
        apb(1'b0, `CCSU_OFF_RESP, 32'h0000_0000);
        q = q & 32'h8000_0000;
        chk("resp_valid", 32'h0000_0000);
    endtask : no_rsp
    task automatic pulse(input logic s, input logic d, input logic c);
        @(posedge clk_sys_i);
        op_s <= s;
        op_d <= d;
        dclr <= c;
        @(posedge clk_sys_i);
        {op_s, op_d, dclr} <= 3'h0;
    endtask : pulse
    task automatic do_reset(input logic p);
        @(posedge clk_sys_i);
        reset_i <= 1'b1;
        nv_psc <= p;
        repeat (5) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask : do_reset
    initial begin
        do_reset(1'b0);
        st(32'h0080_5A00);
        cmd(ccsu_pkg::CMD_ESR_Q, 16'h0000, 8'h00);
        st(32'h0000_5A10);
        rsp(ccsu_pkg::CMD_ESR_Q, 16'h0080);
        for (int i = 0; i < 5; i++) begin
            cmd(ccsu_pkg::CMD_ESE, ea[i], eb[i]);
            cmd(ccsu_pkg::CMD_ESE_Q, 16'h0000, 8'h00);
            rsp(ccsu_pkg::CMD_ESE_Q, ee[i]);
        end
        st(32'h0100_1200);
        @(posedge clk_sys_i) ev[4] <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        ev[4] <= 1'b0;
        st(32'h0110_1220);
        apb(1'b1, `CCSU_OFF_SRE, 32'h0000_0020);
        rd(`CCSU_OFF_SRE, "sre", 32'h0000_0020);
        q = srq_n;
        chk("srq_count", 32'h0000_0001);
        st(32'h0110_1260);
        cmd(ccsu_pkg::CMD_CLS, 16'h0000, 8'h00);
        st(32'h0000_1200);
        q = ce_n;
        chk("clear_count", 32'h0000_0001);
        $display("test status registers done");
        pulse(1'b1, 1'b0, 1'b0);
        cmd(ccsu_pkg::CMD_OPC, 16'h0000, 8'h00);
        st(32'h0000_1200);
        pulse(1'b0, 1'b1, 1'b0);
        st(32'h0001_1200);
        cmd(ccsu_pkg::CMD_CLS, 16'h0000, 8'h00);
        pulse(1'b1, 1'b0, 1'b0);
        cmd(ccsu_pkg::CMD_OPC, 16'h0000, 8'h00);
        cmd(ccsu_pkg::CMD_CLS, 16'h0000, 8'h00);
        pulse(1'b0, 1'b1, 1'b0);
        st(32'h0000_1200);
        pulse(1'b1, 1'b0, 1'b0);
        cmd(ccsu_pkg::CMD_OPC_Q, 16'h0000, 8'h00);
        no_rsp();
        pulse(1'b0, 1'b1, 1'b0);
        rsp(ccsu_pkg::CMD_OPC_Q, 16'h0001);
        pulse(1'b1, 1'b0, 1'b0);
        cmd(ccsu_pkg::CMD_OPC_Q, 16'h0000, 8'h00);
        pulse(1'b0, 1'b0, 1'b1);
        pulse(1'b0, 1'b1, 1'b0);
        no_rsp();
        $display("test completion done");
        cmd(ccsu_pkg::CMD_CAL_Q, 16'h0000, 8'h00);
        rsp(ccsu_pkg::CMD_CAL_Q, 16'h0000);
        @(posedge clk_sys_i) fail <= 1'b1;
        cmd(ccsu_pkg::CMD_CAL_Q, 16'h0000, 8'h00);
        rsp(ccsu_pkg::CMD_CAL_Q, 16'h0001);
        cmd(ccsu_pkg::CMD_PCB, 16'd21, 8'h8C);
        cmd(ccsu_pkg::CMD_PCB, 16'd31, 8'h00);
        rd(`CCSU_OFF_PCB, "pcb", 32'h0000_0C55);
        @(posedge clk_sys_i) rel <= 1'b1;
        @(posedge clk_sys_i) rel <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        q = pb_n;
        chk("pass_back_count", 32'h0000_0001);
        cmd(ccsu_pkg::CMD_PSC, 16'h8001, 8'h00);
        cmd(ccsu_pkg::CMD_PSC, 16'h8000, 8'h00);
        pulse(1'b1, 1'b0, 1'b0);
        cmd(ccsu_pkg::CMD_OPC, 16'h0000, 8'h00);
        cmd(ccsu_pkg::CMD_RST, 16'h0000, 8'h00);
        pulse(1'b0, 1'b1, 1'b0);
        st(32'h0200_1200);
        cmd(ccsu_pkg::CMD_PSC_Q, 16'h0000, 8'h00);
        rsp(ccsu_pkg::CMD_PSC_Q, 16'h0001);
        rd(`CCSU_OFF_PCB, "pcb", 32'h0000_0C55);
        cmd(ccsu_pkg::CMD_IDN_Q, 16'h0000, 8'h00);
        rsp(ccsu_pkg::CMD_IDN_Q, 16'h0000);
        rd(`CCSU_OFF_ID_CO, "company", `CCSU_ID_COMPANY);
        rd(12'h0FC, "unmapped", 32'h0000_0000);
        q = {31'h0, slverr};
        chk("slverr", 32'h0000_0001);
        $display("test settings done");
        do_reset(1'b1);
        st(32'h0080_0000);
        $display("test power clear done");
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
